/* hw/iex_arb.sv */
`timescale 1ns/1ps
module iex_arb
	import iex_pkg::*;
(
	iex_arb_if.arb bus
);
	// Lowest source number wins inside a group
	function automatic logic [PICK_W-1:0] first_set(input logic [SRC_PER_GRP-1:0] v);
		logic [PICK_W-1:0] r;
		r = '0;
		for (int i = SRC_PER_GRP - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = PICK_W'(i);
			end
		end
		return r;
	endfunction

	genvar g;
	generate
		for (g = 0; g < GRP_N; g++) begin : grp
			logic [SRC_PER_GRP-1:0] live;
			assign live = bus.flags[g*SRC_PER_GRP +: SRC_PER_GRP] & bus.enables[g*SRC_PER_GRP +: SRC_PER_GRP];
			assign bus.pend[g] = |live;
			assign bus.pick[g*PICK_W +: PICK_W] = first_set(live);
		end
	endgenerate
endmodule

/* hw/iex_arb_if.sv */
`timescale 1ns/1ps
interface iex_arb_if;
	import iex_pkg::*;
	logic [SRC_N-1:0] flags;
	logic [SRC_N-1:0] enables;
	logic [GRP_N-1:0] pend;
	logic [GRP_N*PICK_W-1:0] pick;
	modport ctl (output flags, output enables, input pend, input pick);
	modport arb (input flags, input enables, output pend, output pick);
endinterface

/* hw/iex_pkg.sv */
package iex_pkg;
	localparam int GRP_N = 12;
	localparam int SRC_PER_GRP = 8;
	localparam int SRC_N = 96;
	localparam int PICK_W = 3;
	localparam int GRP_W = 4;
	localparam int IDX_W = 7;
	localparam int VEC_W = 32;
	localparam int DIR_N = 2;
	localparam int ADDR_W = 12;
	localparam int BYTE_W = 8;
	localparam int STRB_W = 4;
	localparam int FETCH_MAX_CYC = 9;

	localparam logic [ADDR_W-1:0] OFF_CTRL = 12'h000;
	localparam logic [ADDR_W-1:0] OFF_ACK = 12'h004;
	localparam logic [ADDR_W-1:0] OFF_FLAG_BASE = 12'h040;
	localparam logic [ADDR_W-1:0] OFF_FLAG_END = 12'h06c;
	localparam logic [ADDR_W-1:0] OFF_EN_BASE = 12'h080;
	localparam logic [ADDR_W-1:0] OFF_EN_END = 12'h0ac;
	localparam logic [ADDR_W-1:0] OFF_VEC_BASE = 12'h200;
	localparam logic [ADDR_W-1:0] OFF_VEC_END = 12'h37c;

	localparam int CTRL_EN_BIT = 0;
	localparam logic CTRL_EN_RST = 1'b0;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [2:0] {
		IEX_K_NONE = 3'b000,
		IEX_K_CTRL = 3'b001,
		IEX_K_ACK = 3'b010,
		IEX_K_FLAG = 3'b011,
		IEX_K_EN = 3'b100,
		IEX_K_VEC = 3'b101
	} iex_kind_t;
endpackage

/* hw/iex_top.sv */
`timescale 1ns/1ps
module iex_top
	import iex_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [VEC_W-1:0] s_axi_wdata,
	input wire logic [STRB_W-1:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [VEC_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [SRC_N-1:0] src_req,
	input wire logic [DIR_N-1:0] direct_irq_in,
	output logic [GRP_N-1:0] core_irq_line,
	output logic [DIR_N-1:0] core_direct_irq,
	input wire logic fetch_req,
	input wire logic [GRP_W-1:0] fetch_group,
	output logic fetch_valid,
	output logic [VEC_W-1:0] fetch_vector,
	output logic [IDX_W-1:0] fetch_src
);
	function automatic iex_kind_t addr_kind(input logic [ADDR_W-1:0] a);
		if (a[1:0] != 2'b00) begin
			return IEX_K_NONE;
		end else if (a == OFF_CTRL) begin
			return IEX_K_CTRL;
		end else if (a == OFF_ACK) begin
			return IEX_K_ACK;
		end else if (a >= OFF_FLAG_BASE && a <= OFF_FLAG_END) begin
			return IEX_K_FLAG;
		end else if (a >= OFF_EN_BASE && a <= OFF_EN_END) begin
			return IEX_K_EN;
		end else if (a >= OFF_VEC_BASE && a <= OFF_VEC_END) begin
			return IEX_K_VEC;
		end else begin
			return IEX_K_NONE;
		end
	endfunction

	function automatic logic [IDX_W-1:0] addr_idx(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base);
		logic [ADDR_W-1:0] d;
		d = a - base;
		return d[IDX_W+1:2];
	endfunction

	logic [VEC_W-1:0] vec_ram [SRC_N];
	logic [SRC_N-1:0] flags;
	logic [SRC_N-1:0] enables;
	logic [SRC_N-1:0] src_prev;
	logic [SRC_N-1:0] src_rise;
	logic [GRP_N-1:0] ack;
	logic table_en;

	iex_arb_if u_if();
	assign u_if.flags = flags;
	assign u_if.enables = enables;
	iex_arb u_arb (
		.bus(u_if)
	);

	// Write channel: address and data are taken in either order
	logic aw_held;
	logic w_held;
	logic [ADDR_W-1:0] aw_addr;
	logic [VEC_W-1:0] w_data;
	logic [STRB_W-1:0] w_strb;
	logic aw_take;
	logic w_take;
	logic wr_do;
	iex_kind_t wr_kind;
	logic [IDX_W-1:0] wr_idx;

	assign aw_take = s_axi_awvalid & s_axi_awready;
	assign w_take = s_axi_wvalid & s_axi_wready;
	assign wr_do = aw_held & w_held & ~s_axi_bvalid;
	assign wr_kind = addr_kind(aw_addr);
	assign wr_idx = (wr_kind == IEX_K_FLAG) ? addr_idx(aw_addr, OFF_FLAG_BASE) :
		(wr_kind == IEX_K_EN) ? addr_idx(aw_addr, OFF_EN_BASE) : addr_idx(aw_addr, OFF_VEC_BASE);

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			if (aw_take) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (wr_do) begin
				aw_held <= 1'b0;
			end
			if (w_take) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (wr_do) begin
				w_held <= 1'b0;
			end
			s_axi_awready <= ~(aw_take | (aw_held & ~wr_do));
			s_axi_wready <= ~(w_take | (w_held & ~wr_do));
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_do) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (wr_kind == IEX_K_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Vector RAM has no reset; software must fill it before enabling the table
	always_ff @(posedge clk_sys) begin
		if (wr_do && wr_kind == IEX_K_VEC) begin
			for (int b = 0; b < STRB_W; b++) begin
				if (w_strb[b]) begin
					vec_ram[wr_idx][b*BYTE_W +: BYTE_W] <= w_data[b*BYTE_W +: BYTE_W];
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			table_en <= CTRL_EN_RST;
		end else if (wr_do && wr_kind == IEX_K_CTRL && w_strb[0]) begin
			table_en <= w_data[CTRL_EN_BIT];
		end
	end

	// Vector fetch decode, taken from the live flags at the fetch edge
	logic grp_ok;
	logic [GRP_W-1:0] grp_safe;
	logic grp_live;
	logic [PICK_W-1:0] pick_sel;
	logic [IDX_W-1:0] vidx;
	logic fetch_hit;
	logic [SRC_N-1:0] svc_clr;
	logic [GRP_N-1:0] fetch_set;

	assign grp_ok = fetch_group < GRP_W'(GRP_N);
	assign grp_safe = grp_ok ? fetch_group : '0;
	assign grp_live = u_if.pend[grp_safe];
	assign pick_sel = grp_live ? u_if.pick[grp_safe*PICK_W +: PICK_W] : '0;
	assign vidx = {grp_safe, pick_sel};
	assign fetch_hit = fetch_req & grp_ok & table_en & grp_live;
	assign svc_clr = fetch_hit ? (SRC_N'(1) << vidx) : '0;
	assign fetch_set = (fetch_req & grp_ok & table_en) ? (GRP_N'(1) << grp_safe) : '0;

	// Level requests are edge detected so a held request is not re-counted after service
	assign src_rise = src_req & ~src_prev;

	logic [SRC_N-1:0] next_flags;
	always_comb begin
		next_flags = flags;
		if (wr_do && wr_kind == IEX_K_FLAG && w_strb[0]) begin
			next_flags[wr_idx[GRP_W-1:0]*SRC_PER_GRP +: SRC_PER_GRP] = w_data[SRC_PER_GRP-1:0];
		end
		next_flags = next_flags & ~svc_clr;
		next_flags = next_flags | src_rise;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			src_prev <= '0;
			flags <= '0;
		end else begin
			src_prev <= src_req;
			flags <= next_flags;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			enables <= '0;
		end else if (wr_do && wr_kind == IEX_K_EN && w_strb[0]) begin
			enables[wr_idx[GRP_W-1:0]*SRC_PER_GRP +: SRC_PER_GRP] <= w_data[SRC_PER_GRP-1:0];
		end
	end

	// Forwarding and acknowledge; a set in the same cycle as a software clear wins
	logic [GRP_N-1:0] fwd;
	logic [GRP_N-1:0] ack_clr;
	assign fwd = u_if.pend & ~ack;
	assign ack_clr = (wr_do && wr_kind == IEX_K_ACK) ?
		({{(GRP_N-BYTE_W){w_strb[1]}}, {BYTE_W{w_strb[0]}}} & w_data[GRP_N-1:0]) : '0;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ack <= '0;
		end else begin
			ack <= (ack & ~ack_clr) | fwd | fetch_set;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			core_irq_line <= '0;
			core_direct_irq <= '0;
		end else begin
			core_irq_line <= fwd;
			core_direct_irq <= direct_irq_in;
		end
	end

	// One-cycle answer leaves the core most of its nine-cycle budget for context save
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			fetch_valid <= 1'b0;
			fetch_vector <= '0;
			fetch_src <= '0;
		end else begin
			fetch_valid <= fetch_req;
			fetch_src <= vidx;
			fetch_vector <= (table_en && grp_ok) ? vec_ram[vidx] : '0;
		end
	end

	// Read channel
	iex_kind_t rd_kind;
	logic [IDX_W-1:0] rd_idx;
	logic [VEC_W-1:0] rd_word;
	assign rd_kind = addr_kind(s_axi_araddr);
	always_comb begin
		rd_idx = '0;
		rd_word = '0;
		if (rd_kind == IEX_K_CTRL) begin
			rd_word[CTRL_EN_BIT] = table_en;
		end else if (rd_kind == IEX_K_ACK) begin
			rd_word[GRP_N-1:0] = ack;
		end else if (rd_kind == IEX_K_FLAG) begin
			rd_idx = addr_idx(s_axi_araddr, OFF_FLAG_BASE);
			rd_word[SRC_PER_GRP-1:0] = flags[rd_idx[GRP_W-1:0]*SRC_PER_GRP +: SRC_PER_GRP];
		end else if (rd_kind == IEX_K_EN) begin
			rd_idx = addr_idx(s_axi_araddr, OFF_EN_BASE);
			rd_word[SRC_PER_GRP-1:0] = enables[rd_idx[GRP_W-1:0]*SRC_PER_GRP +: SRC_PER_GRP];
		end else if (rd_kind == IEX_K_VEC) begin
			rd_idx = addr_idx(s_axi_araddr, OFF_VEC_BASE);
			rd_word = vec_ram[rd_idx];
		end
	end

	logic ar_take;
	assign ar_take = s_axi_arvalid & s_axi_arready;
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_arready <= ~(ar_take | (s_axi_rvalid & ~s_axi_rready));
			if (ar_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= (rd_kind == IEX_K_NONE) ? RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	sequence fetch_asked;
		fetch_req && grp_ok && table_en;
	endsequence
	sequence fetch_done;
		fetch_valid;
	endsequence

	chk_flag_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(|src_rise) |=> ((flags & $past(src_rise)) == $past(src_rise)))
		else $error("request did not set its flag");
	chk_line_ack: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(|core_irq_line) |-> ((ack & core_irq_line) == core_irq_line))
		else $error("forwarded group without acknowledge set");
	chk_ack_blocks: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(|core_irq_line) |-> (($past(ack) & core_irq_line) == '0))
		else $error("line raised while acknowledge was set");
	chk_line_cause: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(|core_irq_line) |-> (($past(u_if.pend) & core_irq_line) == core_irq_line))
		else $error("line raised without a live source");
	chk_fetch_time: assert property (@(posedge clk_sys) disable iff (!rst_n)
		fetch_asked |-> ##[1:9] fetch_done)
		else $error("vector not answered within nine cycles");
	chk_fetch_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(fetch_asked and fetch_hit) |=> ((flags & $past(svc_clr) & ~$past(src_rise)) == '0))
		else $error("serviced flag not cleared");
	chk_default_vec: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(fetch_asked and !grp_live) |=> (fetch_src == {$past(grp_safe), 3'b000}))
		else $error("empty group did not return first source");
	chk_direct_pass: assert property (@(posedge clk_sys) disable iff (!rst_n)
		1'b1 |=> (core_direct_irq == $past(direct_irq_in)))
		else $error("direct line not passed through");
endmodule

/* verification/iex_core_model.sv */
`timescale 1ns/1ps
module iex_core_model
	import iex_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [GRP_N-1:0] core_irq_line,
	input wire logic [DIR_N-1:0] core_direct_irq,
	input wire logic global_mask_bit,
	input wire logic [15:0] cpu_enable_mask,
	input wire logic cmd_fetch,
	input wire logic [GRP_W-1:0] cmd_group,
	input wire logic fetch_valid,
	output logic fetch_req,
	output logic [GRP_W-1:0] fetch_group
);
	logic [15:0] cpu_pending_flags;
	logic [15:0] live;
	logic [15:0] clr;
	logic busy;
	int pick;
	always_comb begin
		live = cpu_pending_flags & cpu_enable_mask & {16{!global_mask_bit}};
		pick = -1;
		for (int i = GRP_N - 1; i >= 0; i--) begin
			if (live[i]) begin
				pick = i;
			end
		end
		clr = {2'b00, live[13:12], 12'h000};
		if (!busy && !cmd_fetch && pick >= 0) begin
			clr[pick] = 1'b1;
		end
	end
	// One fetch in flight at a time, so a late answer is never paired with the wrong line
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cpu_pending_flags <= 16'h0000;
			busy <= 1'b0;
			fetch_req <= 1'b0;
			fetch_group <= 4'h0;
		end else begin
			cpu_pending_flags <= (cpu_pending_flags | {2'b00, core_direct_irq, core_irq_line}) & ~clr;
			fetch_req <= 1'b0;
			fetch_group <= ~fetch_group;
			if (fetch_valid) begin
				busy <= 1'b0;
			end
			if (!busy && (cmd_fetch || pick >= 0)) begin
				fetch_req <= 1'b1;
				fetch_group <= cmd_fetch ? cmd_group : pick[GRP_W-1:0];
				busy <= 1'b1;
			end
		end
	end
endmodule

/* verification/peripheral_interrupt_expander_tb.sv */
`timescale 1ns/1ps
module peripheral_interrupt_expander_tb
	import iex_pkg::*;
;
	logic clk_sys, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, cmd_fetch;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, fetch_valid, fetch_req;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [VEC_W-1:0] s_axi_wdata, s_axi_rdata, fetch_vector, rd_data, last_vec;
	logic [STRB_W-1:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp;
	logic [SRC_N-1:0] src_req;
	logic [DIR_N-1:0] direct_irq_in, core_direct_irq;
	logic [GRP_N-1:0] core_irq_line;
	logic [GRP_W-1:0] fetch_group, cmd_group;
	logic [IDX_W-1:0] fetch_src, last_src;
	int fails, checks_done, pulse_tot, fetch_n, p0, f0, s, m_ack;
	int m_vec [SRC_N];
	int m_flag [GRP_N];
	int m_en [GRP_N];
	int exp_q [$];
	iex_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.src_req(src_req), .direct_irq_in(direct_irq_in), .core_irq_line(core_irq_line),
		.core_direct_irq(core_direct_irq), .fetch_req(fetch_req), .fetch_group(fetch_group),
		.fetch_valid(fetch_valid), .fetch_vector(fetch_vector), .fetch_src(fetch_src));
	iex_core_model core (.clk_sys(clk_sys), .rst_n(rst_n), .core_irq_line(core_irq_line),
		.core_direct_irq(core_direct_irq), .global_mask_bit(1'b0), .cpu_enable_mask(16'hffff),
		.cmd_fetch(cmd_fetch), .cmd_group(cmd_group), .fetch_valid(fetch_valid), .fetch_req(fetch_req),
		.fetch_group(fetch_group));
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		if (rst_n === 1'b1) begin
			pulse_tot += $countones(core_irq_line);
			if (fetch_valid === 1'b1) begin
				fetch_n++;
				last_vec = fetch_vector;
				last_src = fetch_src;
			end
		end
	end
	task test_done;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task give_up;
		fails++;
		$display("ERROR handshake expected answer seen none");
		test_done();
	endtask
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] st);
		int n;
		n = 0;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= st;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 50);
		s_axi_bready <= 1'b0;
		if (s_axi_bvalid !== 1'b1) give_up();
		chk("bresp", 32'(s_axi_bresp), 32'(RESP_OKAY));
	endtask
	task rd(input logic [ADDR_W-1:0] a);
		int n;
		n = 0;
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 50);
		s_axi_rready <= 1'b0;
		if (s_axi_rvalid !== 1'b1) give_up();
		rd_data = s_axi_rdata;
		rd_resp = s_axi_rresp;
	endtask
	task rchk(input string name, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
		rd(a);
		chk(name, rd_data, exp);
		chk("rresp", 32'(rd_resp), 32'(RESP_OKAY));
	endtask
	// Bounded by the service budget: a slower answer counts as a hang
	task wait_fetch(input int f);
		int n;
		n = 0;
		while (fetch_n == f && n < FETCH_MAX_CYC) begin
			@(negedge clk_sys);
			n++;
		end
		if (fetch_n == f) give_up();
	endtask
	function automatic int low(input int v);
		for (int i = 0; i < SRC_PER_GRP; i++) if (v[i]) return i;
		return 0;
	endfunction
	initial begin
		{clk_sys, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, cmd_fetch} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, src_req, direct_irq_in, cmd_group} = '0;
		{fails, checks_done, pulse_tot, fetch_n, m_ack} = '0;
		void'($urandom(78));
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		rchk("ctrl", OFF_CTRL, 0);
		rchk("ack", OFF_ACK, 0);
		for (int g = 0; g < GRP_N; g++) begin
			rchk("flag", OFF_FLAG_BASE + 12'(4 * g), 0);
			rchk("enable", OFF_EN_BASE + 12'(4 * g), 0);
		end
		rd(12'h100);
		chk("unmapped", 32'(rd_resp), 32'(RESP_SLVERR));
		$display("reset test done");
		for (int i = 0; i < SRC_N; i++) begin
			m_vec[i] = $urandom;
			wr(OFF_VEC_BASE + 12'(4 * i), m_vec[i], 4'hf);
		end
		wr(OFF_VEC_BASE + 12'h014, 32'h5a5a5a5a, 4'h2);
		m_vec[5][15:8] = 8'h5a;
		for (int i = 0; i < SRC_N; i++) rchk("vector", OFF_VEC_BASE + 12'(4 * i), m_vec[i]);
		wr(OFF_CTRL, 1, 4'hf);
		rchk("ctrl", OFF_CTRL, 1);
		$display("vector table test done");
		for (int g = 0; g < GRP_N; g++) begin
			m_en[g] = $urandom_range(255, 1);
			wr(OFF_EN_BASE + 12'(4 * g), ($urandom << 8) | m_en[g], 4'hf);
			rchk("enable", OFF_EN_BASE + 12'(4 * g), m_en[g]);
			p0 = pulse_tot;
			f0 = fetch_n;
			src_req[g * 8 +: 8] <= 8'hff;
			wait_fetch(f0);
			s = low(m_en[g]);
			exp_q.push_back(g * SRC_PER_GRP + s);
			chk("vector", last_vec, m_vec[g * 8 + s]);
			chk("source", 32'(last_src), 32'(exp_q.pop_front()));
			chk("pulses", pulse_tot - p0, 1);
			m_flag[g] = 8'hff & ~(1 << s);
			m_ack |= 1 << g;
			rchk("flag", OFF_FLAG_BASE + 12'(4 * g), m_flag[g]);
			rchk("ack", OFF_ACK, m_ack);
			@(posedge clk_sys) src_req[g * 8 +: 8] <= 8'h00;
			@(posedge clk_sys) src_req[g * 8 +: 8] <= 8'hff;
			wr(OFF_ACK, 0, 4'hf);
			rchk("flag", OFF_FLAG_BASE + 12'(4 * g), 8'hff);
			rchk("ack", OFF_ACK, m_ack);
			chk("held", pulse_tot - p0, 1);
			f0 = fetch_n;
			wr(OFF_ACK, 1 << g, 4'hf);
			wait_fetch(f0);
			exp_q.push_back(g * SRC_PER_GRP + s);
			chk("pulses", pulse_tot - p0, 2);
			chk("vector", last_vec, m_vec[g * 8 + s]);
			chk("source", 32'(last_src), 32'(exp_q.pop_front()));
			rchk("flag", OFF_FLAG_BASE + 12'(4 * g), 8'hff & ~(1 << s));
		end
		$display("group test done");
		wr(OFF_EN_BASE + 12'h02c, 0, 4'hf);
		f0 = fetch_n;
		exp_q.push_back((GRP_N - 1) * SRC_PER_GRP);
		cmd_group <= 4'hb;
		cmd_fetch <= 1'b1;
		@(posedge clk_sys) cmd_fetch <= 1'b0;
		wait_fetch(f0);
		chk("vector", last_vec, m_vec[88]);
		chk("source", 32'(last_src), 32'(exp_q.pop_front()));
		repeat (4) begin
			@(posedge clk_sys) direct_irq_in <= DIR_N'($urandom);
			@(posedge clk_sys);
			@(negedge clk_sys) chk("direct", 32'(core_direct_irq), 32'(direct_irq_in));
		end
		$display("fallback and direct test done");
		test_done();
	end
endmodule
